/* File: src/brsp_regfile_sp.sv */
// Bank/group pointer, stack pointer and operand address translation
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module brsp_regfile_sp import brsp_pkg::*; #(
  parameter int RamHighBits = 2
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] optionByte1,
  input wire brsp_req_t opReq,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire brsp_stk_t stackOp,
  input wire logic [2:0] stackBytes,
  output logic [7:0] regRdata_q,
  output logic regHit_q,
  output brsp_loc_t opLoc_q,
  output logic [11:0] stackAddr_q,
  output logic [7:0] bankGroup_q,
  output logic [15:0] stackPtr_q,
  output logic wideStack_q,
  output logic bankIllegal_q
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] spLow_q;
  logic [7:0] spHigh_q;
  logic optCaught_q;
  logic [15:0] spNext;
  logic [15:0] spPre;
  logic [7:0] spLowNext;
  logic [7:0] spHighNext;
  logic [7:0] bankGroupD;
  brsp_loc_t locNow;
  logic [3:0] bankField;
  // Stack bank bits that the fitted RAM decodes
  localparam logic [1:0] HiMask = 2'((1 << RamHighBits) - 1);

  function automatic logic bank_legal(input logic [3:0] b);
    bank_legal = (b <= 4'h3) || (b == BankD) || (b == BankF);
  endfunction

  // Strap sampled once after reset release; option bits are static
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      optCaught_q <= 1'b0;
      wideStack_q <= 1'b0;
    end else if (!optCaught_q) begin
      optCaught_q <= 1'b1;
      wideStack_q <= optionByte1[StackModeOptBit];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bank/group pointer register
  always_comb begin
    bankGroupD = bankGroup_q;
    if (regWrite && regAddr == RegBankGroupAddr) begin
      bankGroupD = regWdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bankGroup_q <= BankGroupReset;
    end else begin
      bankGroup_q <= bankGroupD;
    end
  end

  assign bankField = bankGroup_q[BankMsb:BankLsb];

  // Flag only; an unimplemented bank is a software fault
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bankIllegal_q <= 1'b0;
    end else begin
      bankIllegal_q <= !bank_legal(bankGroupD[BankMsb:BankLsb]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stack pointer; a push moves the pointer by the number of bytes stored
  always_comb begin
    spPre = {spHigh_q, spLow_q};
    spNext = spPre;
    if (stackOp == BRSP_STK_PUSH) begin
      spNext = spPre - {13'h0000, stackBytes};
    end else if (stackOp == BRSP_STK_POP) begin
      spNext = spPre + {13'h0000, stackBytes};
    end
    spLowNext = spNext[7:0];
    // Narrow mode leaves the user byte untouched
    spHighNext = wideStack_q ? spNext[15:8] : spHigh_q;
    if (regWrite && regAddr == RegStackLowAddr) begin
      spLowNext = regWdata;
    end
    if (regWrite && regAddr == RegStackHighAddr) begin
      spHighNext = regWdata;
    end
  end

  // Pointer bytes have no defined reset value; cleared for determinism
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      spLow_q <= StackResetVal;
      spHigh_q <= StackResetVal;
    end else begin
      spLow_q <= spLowNext;
      spHigh_q <= spHighNext;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stackPtr_q <= {StackResetVal, StackResetVal};
      stackAddr_q <= 12'h000;
    end else begin
      stackPtr_q <= {spHighNext, spLowNext};
      // Address of the top entry after this cycle's update
      if (wideStack_q) begin
        stackAddr_q <= {2'b00, spHighNext[1:0] & HiMask, spLowNext};
      end else begin
        stackAddr_q <= {4'h0, spLowNext};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register readback
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      regRdata_q <= 8'h00;
      regHit_q <= 1'b0;
    end else begin
      regHit_q <= 1'b0;
      regRdata_q <= 8'h00;
      if (regRead) begin
        unique case (regAddr)
          RegBankGroupAddr: begin
            regRdata_q <= bankGroup_q;
            regHit_q <= 1'b1;
          end
          RegStackHighAddr: begin
            regRdata_q <= spHigh_q;
            regHit_q <= 1'b1;
          end
          RegStackLowAddr: begin
            regRdata_q <= spLow_q;
            regHit_q <= 1'b1;
          end
          default: regHit_q <= 1'b0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operand translation
  brsp_addr_map #(.RamHighBits(RamHighBits)) uMap (
    .req(opReq),
    .bankGroup(bankGroup_q),
    .stackPtr({spHigh_q, spLow_q}),
    .wideStack(wideStack_q),
    .loc(locNow)
  );

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      opLoc_q <= '0;
    end else begin
      opLoc_q <= locNow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_ptr_write: assert property (@(posedge clock) disable iff (!rst_n)
    regWrite && regAddr == RegBankGroupAddr |=> bankGroup_q == $past(regWdata))
    else $error("bank/group pointer write lost");

  a_push_dec: assert property (@(posedge clock) disable iff (!rst_n)
    stackOp == BRSP_STK_PUSH && !regWrite && wideStack_q
    |=> stackPtr_q == $past(spPre) - {13'h0000, $past(stackBytes)})
    else $error("push did not predecrement");

  a_pop_inc: assert property (@(posedge clock) disable iff (!rst_n)
    stackOp == BRSP_STK_POP && !regWrite
    |=> stackPtr_q[7:0] == $past(spLow_q) + {5'h00, $past(stackBytes)})
    else $error("pop did not postincrement");

  a_user_hold: assert property (@(posedge clock) disable iff (!rst_n)
    !wideStack_q && stackOp != BRSP_STK_NONE && !regWrite
    |=> stackPtr_q[15:8] == $past(spHigh_q))
    else $error("user byte changed by stack op");

  a_ctrl_bank0: assert property (@(posedge clock) disable iff (!rst_n)
    opReq.valid && opReq.mode == BRSP_MODE_DIRECT && opReq.addr[7:4] == CtrlGroupNibble
    |=> opLoc_q.addr[11:8] == 4'h0)
    else $error("control register not in bank 0");

  a_narrow_stk: assert property (@(posedge clock) disable iff (!rst_n)
    opReq.valid && opReq.mode == BRSP_MODE_STACK && !wideStack_q
    |=> opLoc_q.addr == {4'h0, $past(spLow_q)})
    else $error("narrow stack left bank 0");

  a_wide_stk: assert property (@(posedge clock) disable iff (!rst_n)
    opReq.valid && opReq.mode == BRSP_MODE_STACK && wideStack_q
    |=> opLoc_q.addr == {2'b00, $past(spHigh_q[1:0]) & HiMask, $past(spLow_q)})
    else $error("wide stack address wrong");

  a_linear_pass: assert property (@(posedge clock) disable iff (!rst_n)
    opReq.valid && opReq.mode == BRSP_MODE_LINEAR
    |=> opLoc_q.addr == $past(opReq.addr) && opLoc_q.linear == 2'b01)
    else $error("linear address altered");

  a_work_group: assert property (@(posedge clock) disable iff (!rst_n)
    opReq.valid && opReq.mode == BRSP_MODE_WORK && bankField == 4'h0
    |=> opLoc_q.addr == {4'h0, $past(bankGroup_q[7:4]), $past(opReq.addr[3:0])})
    else $error("working group address wrong");

  a_read_data: assert property (@(posedge clock) disable iff (!rst_n)
    regRead && regAddr == RegBankGroupAddr
    |=> regHit_q && regRdata_q == $past(bankGroup_q))
    else $error("pointer readback wrong");

  a_read_miss: assert property (@(posedge clock) disable iff (!rst_n)
    regRead && regAddr < RegBankGroupAddr
    |=> !regHit_q && regRdata_q == 8'h00)
    else $error("unmapped read answered");

  a_read_idle: assert property (@(posedge clock) disable iff (!rst_n)
    !regRead
    |=> !regHit_q && regRdata_q == 8'h00)
    else $error("read data without a read");

  a_low_write: assert property (@(posedge clock) disable iff (!rst_n)
    regWrite && regAddr == RegStackLowAddr
    |=> stackPtr_q[7:0] == $past(regWdata))
    else $error("stack low byte write lost");

  a_high_write: assert property (@(posedge clock) disable iff (!rst_n)
    regWrite && regAddr == RegStackHighAddr
    |=> stackPtr_q[15:8] == $past(regWdata))
    else $error("stack high byte write lost");

  a_illegal_flag: assert property (@(posedge clock) disable iff (!rst_n)
    bankIllegal_q == !(bankField <= 4'h3 || bankField == BankD || bankField == BankF))
    else $error("unimplemented bank not flagged");

  a_opt_static: assert property (@(posedge clock) disable iff (!rst_n)
    optCaught_q
    |=> $stable(wideStack_q))
    else $error("stack width changed after capture");

  a_narrow_addr: assert property (@(posedge clock) disable iff (!rst_n)
    !wideStack_q
    |-> stackAddr_q == {4'h0, stackPtr_q[7:0]})
    else $error("narrow stack top left bank 0");

  a_wide_addr: assert property (@(posedge clock) disable iff (!rst_n)
    wideStack_q && $past(wideStack_q)
    |-> stackAddr_q == {2'b00, stackPtr_q[9:8] & HiMask, stackPtr_q[7:0]})
    else $error("wide stack top address wrong");

  a_narrow_push: assert property (@(posedge clock) disable iff (!rst_n)
    stackOp == BRSP_STK_PUSH && !regWrite && !wideStack_q
    |=> stackPtr_q[7:0] == $past(spLow_q) - {5'h00, $past(stackBytes)})
    else $error("narrow push did not predecrement");

  a_linear_only: assert property (@(posedge clock) disable iff (!rst_n)
    opReq.valid && opReq.mode != BRSP_MODE_LINEAR
    |=> opLoc_q.linear != 2'b01)
    else $error("linear marking on other operand");

  a_direct_bank: assert property (@(posedge clock) disable iff (!rst_n)
    opReq.valid && opReq.mode == BRSP_MODE_DIRECT && bankField != 4'h0
    && bankField <= 4'h3 && opReq.addr[7:4] != CtrlGroupNibble
    |=> opLoc_q.addr == {$past(bankField), $past(opReq.addr[7:0])})
    else $error("direct access missed selected bank");
endmodule

/* File: common/brsp_pkg.sv */
// Package for the banked register file addressing and stack pointer block
package brsp_pkg;
  localparam logic [7:0] RegBankGroupAddr = 8'hFD;
  localparam logic [7:0] RegStackHighAddr = 8'hFE;
  localparam logic [7:0] RegStackLowAddr = 8'hFF;
  localparam logic [7:0] BankGroupReset = 8'h00;
  localparam logic [7:0] StackResetVal = 8'h00;
  localparam logic [3:0] CtrlGroupNibble = 4'hF;
  localparam int GroupMsb = 7;
  localparam int GroupLsb = 4;
  localparam int BankMsb = 3;
  localparam int BankLsb = 0;
  localparam int StackModeOptBit = 3;
  localparam logic [3:0] BankD = 4'hD;
  localparam logic [3:0] BankF = 4'hF;

  // Kinds of register operand reference from the core
  typedef enum logic [3:0] {
    BRSP_MODE_WORK = 4'b0001,
    BRSP_MODE_DIRECT = 4'b0010,
    BRSP_MODE_LINEAR = 4'b0100,
    BRSP_MODE_STACK = 4'b1000
  } brsp_mode_t;

  // Stack operation request
  typedef enum logic [2:0] {
    BRSP_STK_NONE = 3'b001,
    BRSP_STK_PUSH = 3'b010,
    BRSP_STK_POP = 3'b100
  } brsp_stk_t;

  typedef struct packed {
    logic valid;
    brsp_mode_t mode;
    logic [11:0] addr;
  } brsp_req_t;

  typedef struct packed {
    logic valid;
    logic [11:0] addr;
    logic [1:0] linear;
  } brsp_loc_t;
endpackage

/* File: src/brsp_addr_map.sv */
// Combinational translation of an operand reference into a linear address
`timescale 1ns/1ps
module brsp_addr_map import brsp_pkg::*; #(
  parameter int RamHighBits = 2
) (
  input wire brsp_req_t req,
  input wire logic [7:0] bankGroup,
  input wire logic [15:0] stackPtr,
  input wire logic wideStack,
  output brsp_loc_t loc
);
  logic [3:0] bank;
  logic [7:0] reg8;
  // Stack bank bits that the fitted RAM decodes
  localparam logic [1:0] HiMask = 2'((1 << RamHighBits) - 1);

  always_comb begin
    bank = bankGroup[BankMsb:BankLsb];
    reg8 = req.addr[7:0];
    loc.valid = req.valid;
    loc.linear = 2'b00;
    loc.addr = 12'h000;
    unique case (req.mode)
      BRSP_MODE_WORK: begin
        // Group nibble from pointer
        reg8 = {bankGroup[GroupMsb:GroupLsb], req.addr[3:0]};
      end
      BRSP_MODE_DIRECT: reg8 = req.addr[7:0];
      BRSP_MODE_LINEAR: begin
        loc.linear = 2'b01;
      end
      BRSP_MODE_STACK: begin
        loc.linear = 2'b10;
      end
      // Idle requests carry no mode
      default: reg8 = req.addr[7:0];
    endcase
    if (req.mode == BRSP_MODE_LINEAR) begin
      loc.addr = req.addr;
    end else if (req.mode == BRSP_MODE_STACK) begin
      if (wideStack) begin
        // Bank from low high-byte bits, ignored upper bits
        loc.addr = {2'b00, stackPtr[9:8] & HiMask, stackPtr[7:0]};
      end else begin
        loc.addr = {4'h0, stackPtr[7:0]};
      end
    end else if (reg8[7:4] == CtrlGroupNibble || bank == 4'h0) begin
      loc.addr = {4'h0, reg8};
    end else if ((bank == BankD || bank == BankF) && reg8[7:4] != 4'h0) begin
      // Upper area of these banks falls back to bank 0
      loc.addr = {4'h0, reg8};
    end else begin
      loc.addr = {bank, reg8};
    end
  end
endmodule

/* File: tb/brsp_core_model.sv */
// Core-side model issuing register, stack and operand requests
`timescale 1ns/1ps
module brsp_core_model import brsp_pkg::*; (
  input wire logic clock,
  output logic [7:0] optionByte1,
  output brsp_req_t opReq,
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata,
  output brsp_stk_t stackOp,
  output logic [2:0] stackBytes
);
  initial begin
    opReq = '0;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    stackOp = BRSP_STK_NONE;
    stackBytes = 3'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Static strap level, changed only while reset is held
  task automatic strap(input logic [7:0] v);
    optionByte1 = v;
  endtask
  // Each request sets the signals it drives once, then holds them through the taking edge
  task automatic hold();
    @(posedge clock);
    #1;
  endtask
  // Idle cycle; address and data flip so stale values never match
  task automatic step();
    regWrite = 1'b0;
    regRead = 1'b0;
    opReq.valid = 1'b0;
    stackOp = BRSP_STK_NONE;
    regAddr = ~regAddr;
    regWdata = ~regWdata;
    hold();
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regRead = 1'b0;
    opReq.valid = 1'b0;
    stackOp = BRSP_STK_NONE;
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    hold();
  endtask
  task automatic rd(input logic [7:0] a);
    regWrite = 1'b0;
    opReq.valid = 1'b0;
    stackOp = BRSP_STK_NONE;
    regAddr = a;
    regRead = 1'b1;
    hold();
  endtask
  // Callers keep the wide pointer clear of wrap; narrow push wraps low byte, user byte never a loop count
  task automatic stk(input brsp_stk_t k, input logic [2:0] n);
    regWrite = 1'b0;
    regRead = 1'b0;
    opReq.valid = 1'b0;
    stackBytes = n;
    stackOp = k;
    hold();
  endtask
  task automatic op(input brsp_mode_t m, input logic [11:0] a);
    regWrite = 1'b0;
    regRead = 1'b0;
    stackOp = BRSP_STK_NONE;
    opReq = '{valid: 1'b1, mode: m, addr: a};
    hold();
  endtask
endmodule

/* File: tb/banked_regfile_stack_pointer_bench.sv */
// Self-checking bench for the register file addressing and stack pointer block
`timescale 1ns/1ps
module banked_regfile_stack_pointer_bench import brsp_pkg::*;;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] optionByte1, regAddr, regWdata, regRdata_q, bankGroup_q;
  brsp_req_t opReq;
  logic regWrite, regRead, regHit_q, wideStack_q, bankIllegal_q;
  brsp_stk_t stackOp;
  logic [2:0] stackBytes;
  brsp_loc_t opLoc_q;
  logic [11:0] stackAddr_q;
  logic [15:0] stackPtr_q;
  int errors = 0;
  int totalChecks = 0;
  int cycles = 0;

  always #12.5 clock = ~clock;

  brsp_core_model core (.clock(clock), .optionByte1(optionByte1), .opReq(opReq),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
    .stackOp(stackOp), .stackBytes(stackBytes));

  brsp_regfile_sp #(.RamHighBits(2)) uut (.clock(clock), .rst_n(rst_n),
    .optionByte1(optionByte1), .opReq(opReq), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .stackOp(stackOp), .stackBytes(stackBytes),
    .regRdata_q(regRdata_q), .regHit_q(regHit_q), .opLoc_q(opLoc_q),
    .stackAddr_q(stackAddr_q), .bankGroup_q(bankGroup_q), .stackPtr_q(stackPtr_q),
    .wideStack_q(wideStack_q), .bankIllegal_q(bankIllegal_q));
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (errors == 0 && totalChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic loc(input brsp_mode_t m, input logic [11:0] a, input logic [11:0] e,
                     input logic [1:0] lin);
    core.op(m, a);
    chk({3'h0, opLoc_q.valid, opLoc_q.addr}, {4'h1, e});
    chk(16'(opLoc_q.linear), 16'(lin));
  endtask
  task automatic doReset(input logic [7:0] opt);
    rst_n = 1'b0;
    core.strap(opt);
    repeat (6) @(posedge clock);
    #1;
    rst_n = 1'b1;
    repeat (2) @(posedge clock);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Ceiling well above the 50 or so cycles the sequence needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      tally_and_finish();
    end
  end

  initial begin
    doReset(8'h08);
    chk(16'(bankGroup_q), 16'h0000);
    chk(16'(wideStack_q), 16'h0001);
    core.wr(RegBankGroupAddr, 8'h23);
    chk(16'(bankGroup_q), 16'h0023);
    core.rd(RegBankGroupAddr);
    chk({7'h0, regHit_q, regRdata_q}, 16'h0123);
    core.rd(8'h10);
    chk({7'h0, regHit_q, regRdata_q}, 16'h0000);
    loc(BRSP_MODE_WORK, 12'h000, 12'h320, 2'b00);
    loc(BRSP_MODE_WORK, 12'h007, 12'h327, 2'b00);
    loc(BRSP_MODE_DIRECT, 12'h045, 12'h345, 2'b00);
    loc(BRSP_MODE_DIRECT, 12'h0F5, 12'h0F5, 2'b00);
    loc(BRSP_MODE_LINEAR, 12'hD07, 12'hD07, 2'b01);
    loc(BRSP_MODE_LINEAR, 12'h1FF, 12'h1FF, 2'b01);
    core.wr(RegBankGroupAddr, 8'h20);
    loc(BRSP_MODE_DIRECT, 12'h045, 12'h045, 2'b00);
    loc(BRSP_MODE_WORK, 12'h00A, 12'h02A, 2'b00);
    core.wr(RegBankGroupAddr, 8'h0D);
    loc(BRSP_MODE_DIRECT, 12'h020, 12'h020, 2'b00);
    loc(BRSP_MODE_DIRECT, 12'h005, 12'hD05, 2'b00);
    chk(16'(bankIllegal_q), 16'h0000);
    core.wr(RegBankGroupAddr, 8'h04);
    core.step();
    chk(16'(bankIllegal_q), 16'h0001);
    core.wr(RegStackHighAddr, 8'h03);
    core.wr(RegStackLowAddr, 8'h00);
    core.stk(BRSP_STK_PUSH, 3'd2);
    chk(stackPtr_q, 16'h02FE);
    chk(16'(stackAddr_q), 16'h02FE);
    core.wr(RegStackHighAddr, 8'hFD);
    core.stk(BRSP_STK_PUSH, 3'd3);
    chk(stackPtr_q, 16'hFDFB);
    chk(16'(stackAddr_q), 16'h01FB);
    core.stk(BRSP_STK_POP, 3'd3);
    loc(BRSP_MODE_STACK, 12'h000, 12'h1FE, 2'b10);
    core.stk(BRSP_STK_POP, 3'd2);
    chk(stackPtr_q, 16'hFE00);
    chk(16'(stackAddr_q), 16'h0200);
    core.step();
    doReset(8'h00);
    chk(16'(wideStack_q), 16'h0000);
    core.wr(RegStackHighAddr, 8'h5A);
    core.wr(RegStackLowAddr, 8'h00);
    core.stk(BRSP_STK_PUSH, 3'd1);
    chk(stackPtr_q, 16'h5AFF);
    chk(16'(stackAddr_q), 16'h00FF);
    loc(BRSP_MODE_STACK, 12'h000, 12'h0FF, 2'b10);
    core.rd(RegStackHighAddr);
    chk({7'h0, regHit_q, regRdata_q}, 16'h015A);
    core.wr(RegStackLowAddr, 8'h3C);
    core.rd(RegStackLowAddr);
    chk({7'h0, regHit_q, regRdata_q}, 16'h013C);
    tally_and_finish();
  end
endmodule
